//--- shared/dbg_uart_map.svh
`ifndef DBG_UART_MAP_SVH
`define DBG_UART_MAP_SVH

// Register byte offsets
`define UR_OFS_CTRL   8'h00
`define UR_OFS_MODE   8'h04
`define UR_OFS_IEN    8'h08
`define UR_OFS_IDIS   8'h0c
`define UR_OFS_IMASK  8'h10
`define UR_OFS_STAT   8'h14
`define UR_OFS_RHOLD  8'h18
`define UR_OFS_THOLD  8'h1c
`define UR_OFS_BAUD   8'h20

// Control command bits
`define UR_B_RST_RX   2
`define UR_B_RST_TX   3
`define UR_B_RX_ON    4
`define UR_B_RX_OFF   5
`define UR_B_TX_ON    6
`define UR_B_TX_OFF   7
`define UR_B_CLR_ERR  8

// Status and mask bit positions
`define UR_S_RX_PEND  0
`define UR_S_TX_FREE  1
`define UR_S_RX_DMA   3
`define UR_S_TX_DMA   4
`define UR_S_OVR      5
`define UR_S_FRAME    6
`define UR_S_PAR      7
`define UR_S_TX_IDLE  9
`define UR_S_TX_DRAIN 11
`define UR_S_RX_FILL  12
`define UR_S_DCC_WR   30
`define UR_S_DCC_RD   31
`define UR_SRC_MASK   32'hc0001afb

// Mode and baud fields, reset values
`define UR_PAR_LSB    9
`define UR_PAR_W      3
`define UR_MODE_RST   3'h0
`define UR_BAUD_W     16
`define UR_BAUD_RST   16'h0000
`define UR_MASK_RST   32'h00000000

// Line timing in oversampling ticks, and the index of the last data bit
`define UR_OVS_LAST   4'hf
`define UR_OVS_MID    4'h7
`define UR_LAST_BIT   3'h7

`endif

//--- shared/dbg_uart_pkg.sv
package dbg_uart_pkg;
  typedef logic [7:0] char_t;
  typedef enum logic [2:0] {
    LN_IDLE  = 3'h0,
    LN_START = 3'h1,
    LN_DATA  = 3'h2,
    LN_PAR   = 3'h3,
    LN_STOP  = 3'h4
  } line_state_e;

  // Mode bit 2 high means no parity bit on the line
  function automatic logic par_on(input logic [2:0] mode);
    return !mode[2];
  endfunction

  // Even, odd, forced space, forced mark
  function automatic logic par_calc(input logic [2:0] mode, input char_t d);
    unique case (mode[1:0])
      2'h0: return ^d;
      2'h1: return ~^d;
      2'h2: return 1'b0;
      2'h3: return 1'b1;
    endcase
  endfunction
endpackage

//--- rtl/pair_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] slot_ff [2];
  logic             wptr_ff;
  logic             rptr_ff;
  logic [1:0]       count_ff;
  logic             push;
  logic             pop;

  // Honest full and empty from the occupancy count
  assign in_ready  = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  assign out_data  = slot_ff[rptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage has no reset; only the count matters
  always_ff @(posedge ref_clk) begin
    if (push) begin
      slot_ff[wptr_ff] <= in_data;
    end
  end

  // Pointers and count; flush drops both entries
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wptr_ff  <= 1'b0;
      rptr_ff  <= 1'b0;
      count_ff <= 2'h0;
    end else if (flush) begin
      wptr_ff  <= 1'b0;
      rptr_ff  <= 1'b0;
      count_ff <= 2'h0;
    end else begin
      if (push) wptr_ff <= ~wptr_ff;
      if (pop) rptr_ff <= ~rptr_ff;
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

//--- rtl/uart_rx_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbg_uart_map.svh"
module uart_rx_core (
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  input  wire logic                clear,
  input  wire logic                enable,
  input  wire logic                tick16,
  input  wire logic                rxd,
  input  wire logic [2:0]          par_mode,
  output logic                     char_valid,
  output dbg_uart_pkg::char_t      char_data,
  output logic                     frame_err,
  output logic                     par_err
);
  dbg_uart_pkg::line_state_e state_ff;
  logic [3:0]                cnt_ff;
  logic [2:0]                bit_ff;
  logic                      par_bad_ff;

  // Enable is only looked at before a start bit, so a
  // disable lets the current character finish
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff   <= dbg_uart_pkg::LN_IDLE;
      cnt_ff     <= 4'h0;
      bit_ff     <= 3'h0;
      par_bad_ff <= 1'b0;
      char_data  <= 8'h00;
      char_valid <= 1'b0;
      frame_err  <= 1'b0;
      par_err    <= 1'b0;
    end else begin
      char_valid <= 1'b0;
      frame_err  <= 1'b0;
      par_err    <= 1'b0;
      if (clear) begin
        state_ff <= dbg_uart_pkg::LN_IDLE;
      end else unique case (state_ff)
        dbg_uart_pkg::LN_IDLE: begin
          cnt_ff     <= 4'h0;
          par_bad_ff <= 1'b0;
          if (enable && !rxd) state_ff <= dbg_uart_pkg::LN_START;
        end
        dbg_uart_pkg::LN_START: if (tick16) begin
          cnt_ff <= cnt_ff + 4'h1;
          // Mid-bit recheck rejects short glitches
          if (cnt_ff == `UR_OVS_MID) begin
            cnt_ff   <= 4'h0;
            bit_ff   <= 3'h0;
            state_ff <= rxd ? dbg_uart_pkg::LN_IDLE : dbg_uart_pkg::LN_DATA;
          end
        end
        dbg_uart_pkg::LN_DATA: if (tick16) begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == `UR_OVS_LAST) begin
            char_data <= {rxd, char_data[7:1]};
            bit_ff    <= bit_ff + 3'h1;
            if (bit_ff == `UR_LAST_BIT) begin
              state_ff <= dbg_uart_pkg::par_on(par_mode) ? dbg_uart_pkg::LN_PAR : dbg_uart_pkg::LN_STOP;
            end
          end
        end
        dbg_uart_pkg::LN_PAR: if (tick16) begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == `UR_OVS_LAST) begin
            par_bad_ff <= (rxd != dbg_uart_pkg::par_calc(par_mode, char_data));
            state_ff   <= dbg_uart_pkg::LN_STOP;
          end
        end
        dbg_uart_pkg::LN_STOP: if (tick16) begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == `UR_OVS_LAST) begin
            char_valid <= 1'b1;
            frame_err  <= !rxd;
            par_err    <= par_bad_ff;
            state_ff   <= dbg_uart_pkg::LN_IDLE;
          end
        end
        default: state_ff <= dbg_uart_pkg::LN_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- rtl/debug_uart_status_irq_regs.sv
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dbg_uart_map.svh"
// How it works
// RQ1 - Writing ones to irq_disable clears those mask bits; zeros change nothing.
// RQ2 - irq_mask reads back the enabled sources at status bit positions.
// RQ3 - Receive pending sets on holding load; clears on read or receiver disable.
// RQ4 - Holding free is low while a char waits or transmitter is off.
// RQ5 - Status bit 3 follows the receive DMA end-of-transfer input.
// RQ6 - Status bit 4 follows the transmit DMA end-of-transfer input.
// RQ7 - Overrun flag sets on any overrun, holds until error clear command.
// RQ8 - Framing flag sets on any framing error, holds until error clear.
// RQ9 - Parity flag sets on any parity error, holds until error clear.
// RQ10 - Transmit idle only with empty holding, no shifting, transmitter on.
// RQ11 - Status bit 11 follows the transmit DMA buffer-drained input.
// RQ12 - Status bit 12 follows the receive DMA buffer-filled input.
// RQ13 - Status bit 30 follows the core's channel write status.
// RQ14 - Status bit 31 follows the core's channel read status.
// RQ15 - rx_holding shows the last received character in its low byte.
// RQ16 - Software writes tx_holding only while holding is free; the code accepts any write while the transmitter is on.
// RQ17 - Error clear command bit clears parity, framing and overrun flags.
// RQ18 - Writing ones to irq_enable sets those mask bits; zeros change nothing.
// RQ19 - Interrupt is high while any status bit meets its mask bit.
module debug_uart_status_irq_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              rxd,
  output logic                   txd,
  input  wire logic              rx_dma_transfer_done,
  input  wire logic              tx_dma_transfer_done,
  input  wire logic              tx_dma_buffer_drained,
  input  wire logic              rx_dma_buffer_filled,
  input  wire logic              dcc_write_status,
  input  wire logic              dcc_read_status,
  output logic                   irq
);
  logic [31:0]               mask_ff;
  logic [31:0]               status_w;
  logic [31:0]               rd_data_ff;
  logic                      rx_en_ff;
  logic                      tx_en_ff;
  logic [`UR_PAR_W-1:0]      mode_par_ff;
  logic [`UR_BAUD_W-1:0]     baud_div_ff;
  logic [`UR_BAUD_W-1:0]     baud_cnt_ff;
  logic                      tick16;
  logic [2:0]                rxd_sync_ff;
  logic                      rxd_filt_ff;
  logic                      rx_char_valid;
  dbg_uart_pkg::char_t       rx_char_data;
  logic                      rx_frame_err;
  logic                      rx_par_err;
  logic                      rxbuf_in_ready;
  logic                      rxbuf_out_valid;
  dbg_uart_pkg::char_t       rxbuf_out_data;
  logic                      rhr_load;
  dbg_uart_pkg::char_t       rhr_ff;
  logic                      rx_pend_ff;
  logic [2:0]                err_ff;
  logic [2:0]                err_evt;
  logic                      thr_full_ff;
  dbg_uart_pkg::char_t       thr_data_ff;
  logic                      tx_load;
  dbg_uart_pkg::line_state_e tx_state_ff;
  logic [3:0]                tx_cnt_ff;
  logic [2:0]                tx_bit_ff;
  dbg_uart_pkg::char_t       tx_shift_ff;
  logic                      tx_par_ff;
  // Address match, shared by all strobe decodes
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction
  logic wr_ctrl, wr_mode, wr_ien, wr_idis, wr_thold, wr_baud, rd_rhold;
  logic cmd_rst_rx, cmd_rst_tx, cmd_rx_on, cmd_rx_off, cmd_tx_on, cmd_tx_off, cmd_clr_err;
  // Write strobes, the holding read strobe and control commands
  assign wr_ctrl     = reg_wr && hit(reg_addr, `UR_OFS_CTRL);
  assign wr_mode     = reg_wr && hit(reg_addr, `UR_OFS_MODE);
  assign wr_ien      = reg_wr && hit(reg_addr, `UR_OFS_IEN);
  assign wr_idis     = reg_wr && hit(reg_addr, `UR_OFS_IDIS);
  assign wr_thold    = reg_wr && hit(reg_addr, `UR_OFS_THOLD);
  assign wr_baud     = reg_wr && hit(reg_addr, `UR_OFS_BAUD);
  assign rd_rhold    = reg_rd && hit(reg_addr, `UR_OFS_RHOLD);
  assign cmd_rst_rx  = wr_ctrl && reg_wdata[`UR_B_RST_RX];
  assign cmd_rst_tx  = wr_ctrl && reg_wdata[`UR_B_RST_TX];
  assign cmd_rx_on   = wr_ctrl && reg_wdata[`UR_B_RX_ON];
  assign cmd_rx_off  = wr_ctrl && reg_wdata[`UR_B_RX_OFF];
  assign cmd_tx_on   = wr_ctrl && reg_wdata[`UR_B_TX_ON];
  assign cmd_tx_off  = wr_ctrl && reg_wdata[`UR_B_TX_OFF];
  assign cmd_clr_err = wr_ctrl && reg_wdata[`UR_B_CLR_ERR];
  // Enables: disable and reset win over enable in one write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_en_ff <= 1'b0;
      tx_en_ff <= 1'b0;
    end else begin
      if (cmd_rst_rx || cmd_rx_off) rx_en_ff <= 1'b0;
      else if (cmd_rx_on) rx_en_ff <= 1'b1;
      if (cmd_rst_tx || cmd_tx_off) tx_en_ff <= 1'b0;
      else if (cmd_tx_on) tx_en_ff <= 1'b1;
    end
  end
  // Mode and divisor registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_par_ff <= `UR_MODE_RST;
      baud_div_ff <= `UR_BAUD_RST;
    end else begin
      if (wr_mode) mode_par_ff <= reg_wdata[`UR_PAR_LSB +: `UR_PAR_W];
      if (wr_baud) baud_div_ff <= reg_wdata[`UR_BAUD_W-1:0];
    end
  end
  // Interrupt mask: set and clear registers, never both in one cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mask_ff <= `UR_MASK_RST;
    end else if (wr_ien) begin
      mask_ff <= mask_ff | (reg_wdata & `UR_SRC_MASK); // RQ18
    end else if (wr_idis) begin
      mask_ff <= mask_ff & ~(reg_wdata & `UR_SRC_MASK); // RQ1
    end
  end
  // Sixteen-times tick; divisor 0 stops it, 1 ticks every cycle
  assign tick16 = (baud_div_ff != `UR_BAUD_RST) && (baud_cnt_ff == baud_div_ff - 16'h0001);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) baud_cnt_ff <= `UR_BAUD_RST;
    else if (tick16 || baud_div_ff == `UR_BAUD_RST) baud_cnt_ff <= `UR_BAUD_RST;
    else baud_cnt_ff <= baud_cnt_ff + 16'h0001;
  end
  // Three-stage pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxd_sync_ff <= 3'h7;
      rxd_filt_ff <= 1'b1;
    end else begin
      rxd_sync_ff <= {rxd_sync_ff[1:0], rxd};
      if (rxd_sync_ff[1] == rxd_sync_ff[2]) rxd_filt_ff <= rxd_sync_ff[2];
    end
  end
  uart_rx_core u_rx (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .clear      (cmd_rst_rx),
    .enable     (rx_en_ff),
    .tick16     (tick16),
    .rxd        (rxd_filt_ff),
    .par_mode   (mode_par_ff),
    .char_valid (rx_char_valid),
    .char_data  (rx_char_data),
    .frame_err  (rx_frame_err),
    .par_err    (rx_par_err)
  );
  // Two characters of slack between line and holding register
  pair_buffer #(.WIDTH(8)) u_rxbuf (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .flush     (cmd_rst_rx),
    .in_valid  (rx_char_valid),
    .in_ready  (rxbuf_in_ready),
    .in_data   (rx_char_data),
    .out_valid (rxbuf_out_valid),
    .out_ready (rhr_load),
    .out_data  (rxbuf_out_data)
  );
  // Holding refills in the read cycle itself, so a back-to-back read sees the next char
  assign rhr_load = rxbuf_out_valid && rx_en_ff && (!rx_pend_ff || rd_rhold);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rhr_ff     <= 8'h00;
      rx_pend_ff <= 1'b0;
    end else begin
      if (rhr_load) rhr_ff <= rxbuf_out_data; // RQ15
      if (!rx_en_ff) rx_pend_ff <= 1'b0; // RQ3
      else if (rhr_load) rx_pend_ff <= 1'b1; // RQ3
      else if (rd_rhold) rx_pend_ff <= 1'b0; // RQ3
    end
  end
  // Sticky errors; a new event beats a clear in the same cycle
  assign err_evt = {rx_par_err, rx_frame_err, rx_char_valid && !rxbuf_in_ready};
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) err_ff <= 3'h0;
    else err_ff <= (err_ff & ~{3{cmd_clr_err}}) | err_evt; // RQ7 RQ8 RQ9 RQ17
  end

  // Transmit holding; a write while disabled is dropped
  assign tx_load = thr_full_ff && (tx_state_ff == dbg_uart_pkg::LN_IDLE);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      thr_full_ff <= 1'b0;
      thr_data_ff <= 8'h00;
    end else if (cmd_rst_tx) begin
      thr_full_ff <= 1'b0;
    end else if (wr_thold && tx_en_ff) begin
      thr_full_ff <= 1'b1; // RQ4
      thr_data_ff <= reg_wdata[7:0];
    end else if (tx_load) begin
      thr_full_ff <= 1'b0;
    end
  end

  // Shifter runs on after disable so queued characters still go out
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_state_ff <= dbg_uart_pkg::LN_IDLE;
      tx_cnt_ff   <= 4'h0;
      tx_bit_ff   <= 3'h0;
      tx_shift_ff <= 8'h00;
      tx_par_ff   <= 1'b0;
      txd         <= 1'b1;
    end else if (cmd_rst_tx) begin
      tx_state_ff <= dbg_uart_pkg::LN_IDLE;
      txd         <= 1'b1;
    end else unique case (tx_state_ff)
      dbg_uart_pkg::LN_IDLE: begin
        txd       <= 1'b1;
        tx_cnt_ff <= 4'h0;
        if (tx_load) begin
          tx_shift_ff <= thr_data_ff;
          tx_par_ff   <= dbg_uart_pkg::par_calc(mode_par_ff, thr_data_ff);
          tx_state_ff <= dbg_uart_pkg::LN_START;
          txd         <= 1'b0;
        end
      end
      dbg_uart_pkg::LN_START: if (tick16) begin
        tx_cnt_ff <= tx_cnt_ff + 4'h1;
        if (tx_cnt_ff == `UR_OVS_LAST) begin
          txd         <= tx_shift_ff[0];
          tx_bit_ff   <= 3'h0;
          tx_state_ff <= dbg_uart_pkg::LN_DATA;
        end
      end
      dbg_uart_pkg::LN_DATA: if (tick16) begin
        tx_cnt_ff <= tx_cnt_ff + 4'h1;
        if (tx_cnt_ff == `UR_OVS_LAST) begin
          tx_bit_ff <= tx_bit_ff + 3'h1;
          if (tx_bit_ff != `UR_LAST_BIT) begin
            tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
            txd         <= tx_shift_ff[1];
          end else if (dbg_uart_pkg::par_on(mode_par_ff)) begin
            txd         <= tx_par_ff;
            tx_state_ff <= dbg_uart_pkg::LN_PAR;
          end else begin
            txd         <= 1'b1;
            tx_state_ff <= dbg_uart_pkg::LN_STOP;
          end
        end
      end
      dbg_uart_pkg::LN_PAR: if (tick16) begin
        tx_cnt_ff <= tx_cnt_ff + 4'h1;
        if (tx_cnt_ff == `UR_OVS_LAST) begin
          txd         <= 1'b1;
          tx_state_ff <= dbg_uart_pkg::LN_STOP;
        end
      end
      dbg_uart_pkg::LN_STOP: if (tick16) begin
        tx_cnt_ff <= tx_cnt_ff + 4'h1;
        if (tx_cnt_ff == `UR_OVS_LAST) tx_state_ff <= dbg_uart_pkg::LN_IDLE;
      end
      default: tx_state_ff <= dbg_uart_pkg::LN_IDLE;
    endcase
  end

  // Status word; DMA and channel inputs pass straight through
  always_comb begin
    status_w                 = 32'h00000000;
    status_w[`UR_S_RX_PEND]  = rx_pend_ff;
    status_w[`UR_S_TX_FREE]  = tx_en_ff && !thr_full_ff; // RQ4
    status_w[`UR_S_RX_DMA]   = rx_dma_transfer_done; // RQ5
    status_w[`UR_S_TX_DMA]   = tx_dma_transfer_done; // RQ6
    status_w[`UR_S_OVR]      = err_ff[0];
    status_w[`UR_S_FRAME]    = err_ff[1];
    status_w[`UR_S_PAR]      = err_ff[2];
    status_w[`UR_S_TX_IDLE]  = tx_en_ff && !thr_full_ff && (tx_state_ff == dbg_uart_pkg::LN_IDLE); // RQ10
    status_w[`UR_S_TX_DRAIN] = tx_dma_buffer_drained; // RQ11
    status_w[`UR_S_RX_FILL]  = rx_dma_buffer_filled; // RQ12
    status_w[`UR_S_DCC_WR]   = dcc_write_status; // RQ13
    status_w[`UR_S_DCC_RD]   = dcc_read_status; // RQ14
  end

  assign irq = |(status_w & mask_ff); // RQ19

  // Read data stand one cycle; unmapped and idle cycles read zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_ff <= 32'h00000000;
    end else if (!reg_rd) begin
      rd_data_ff <= 32'h00000000;
    end else if (hit(reg_addr, `UR_OFS_MODE)) begin
      rd_data_ff <= 32'(mode_par_ff) << `UR_PAR_LSB;
    end else if (hit(reg_addr, `UR_OFS_IMASK)) begin
      rd_data_ff <= mask_ff; // RQ2
    end else if (hit(reg_addr, `UR_OFS_STAT)) begin
      rd_data_ff <= status_w;
    end else if (hit(reg_addr, `UR_OFS_RHOLD)) begin
      rd_data_ff <= {24'h000000, rhr_ff}; // RQ15
    end else if (hit(reg_addr, `UR_OFS_BAUD)) begin
      rd_data_ff <= 32'(baud_div_ff);
    end else begin
      rd_data_ff <= 32'h00000000;
    end
  end
  assign reg_rdata = rd_data_ff;

  property p_idis_clears;
    @(posedge ref_clk) disable iff (!nrst)
    wr_idis |=> ((mask_ff & $past(reg_wdata)) == 32'h0) && ((mask_ff | $past(reg_wdata)) == ($past(mask_ff) | $past(reg_wdata)));
  endproperty
  a_idis_clears: assert property (p_idis_clears) else $error("disable write wrong"); // RQ1
  property p_ien_sets;
    @(posedge ref_clk) disable iff (!nrst)
    wr_ien |=> mask_ff == ($past(mask_ff) | ($past(reg_wdata) & `UR_SRC_MASK));
  endproperty
  a_ien_sets: assert property (p_ien_sets) else $error("enable write wrong"); // RQ18
  property p_mask_read;
    @(posedge ref_clk) disable iff (!nrst)
    reg_rd && hit(reg_addr, `UR_OFS_IMASK) |=> reg_rdata == $past(mask_ff);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask readback wrong"); // RQ2
  property p_rx_off;
    @(posedge ref_clk) disable iff (!nrst)
    !rx_en_ff |=> !rx_pend_ff;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("pending while disabled"); // RQ3
  property p_thr_busy;
    @(posedge ref_clk) disable iff (!nrst)
    wr_thold && !cmd_rst_tx |=> !status_w[`UR_S_TX_FREE] && !status_w[`UR_S_TX_IDLE];
  endproperty
  a_thr_busy: assert property (p_thr_busy) else $error("holding free after write"); // RQ4 RQ10
  property p_ovr_sticky;
    @(posedge ref_clk) disable iff (!nrst)
    (status_w[`UR_S_OVR] && !cmd_clr_err) || (rx_char_valid && !rxbuf_in_ready) |=> status_w[`UR_S_OVR];
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun lost"); // RQ7
  property p_frame_sticky;
    @(posedge ref_clk) disable iff (!nrst)
    (status_w[`UR_S_FRAME] && !cmd_clr_err) || rx_frame_err |=> status_w[`UR_S_FRAME];
  endproperty
  a_frame_sticky: assert property (p_frame_sticky) else $error("framing flag lost"); // RQ8
  property p_par_sticky;
    @(posedge ref_clk) disable iff (!nrst)
    (status_w[`UR_S_PAR] && !cmd_clr_err) || rx_par_err |=> status_w[`UR_S_PAR];
  endproperty
  a_par_sticky: assert property (p_par_sticky) else $error("parity flag lost"); // RQ9
  property p_err_clear;
    @(posedge ref_clk) disable iff (!nrst)
    cmd_clr_err && !rx_char_valid |=> status_w[`UR_S_PAR:`UR_S_OVR] == 3'h0;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error clear failed"); // RQ17
  property p_pass_through;
    @(posedge ref_clk) disable iff (!nrst)
    reg_rd && hit(reg_addr, `UR_OFS_STAT) |=> {reg_rdata[31:30], reg_rdata[12:11], reg_rdata[4:3]} ==
      $past({dcc_read_status, dcc_write_status, rx_dma_buffer_filled, tx_dma_buffer_drained,
             tx_dma_transfer_done, rx_dma_transfer_done});
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("status input wrong"); // RQ5 RQ6 RQ11 RQ12 RQ13 RQ14
  property p_rhold_read;
    @(posedge ref_clk) disable iff (!nrst)
    rd_rhold && rx_pend_ff |=> reg_rdata == {24'h000000, $past(rhr_ff)};
  endproperty
  a_rhold_read: assert property (p_rhold_read) else $error("holding read wrong"); // RQ15
endmodule
`default_nettype wire

//--- verif/uart_host.sv
`timescale 1ns/1ps
`default_nettype none
// Serial host on the far side, 16 cycles a bit at divisor 1
module uart_host (
  input  wire logic ref_clk,
  input  wire logic txd,
  output var logic  rxd
);
  initial rxd = 1'b1;
  // Start, 8 data LSB first, even parity, stop, one idle bit so frames never abut
  task automatic send(input logic [7:0] d, input logic bad_par, input logic stop);
    logic [11:0] f;
    f = {1'b1, stop, ^d ^ bad_par, d, 1'b0};
    for (int i = 0; i < 12; i++) begin
      rxd <= f[i];
      repeat (16) @(posedge ref_clk);
    end
  endtask
  // Samples mid-bit, then waits through parity and returns in the middle of the stop bit
  task automatic get(output logic [7:0] d);
    @(negedge txd);
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge ref_clk);
      d[i] = txd;
    end
    repeat (32) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        ref_clk, nrst, reg_wr, reg_rd, txd, rxd, irq;
  logic [7:0]  reg_addr, c0, c1;
  logic [31:0] reg_wdata, reg_rdata;
  logic [5:0]  raw;
  int          num_errors, tests_run, cycles;
  int          bitpos [6] = '{3, 4, 11, 12, 30, 31};
  debug_uart_status_irq_regs dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd),
    .rx_dma_transfer_done(raw[0]), .tx_dma_transfer_done(raw[1]), .tx_dma_buffer_drained(raw[2]),
    .rx_dma_buffer_filled(raw[3]), .dcc_write_status(raw[4]), .dcc_read_status(raw[5]), .irq(irq));
  uart_host host (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Whole run is a few thousand cycles; the ceiling leaves ample slack
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude();
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bus cycles: strobe for one cycle, read data taken in the cycle after
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] m, exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(what, reg_rdata & m, exp);
  endtask
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, raw} = '0;
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    rc("mask", 8'h10, '1, 32'h0);
    rc("unmapped", 8'h24, '1, 32'h0);
    wr(8'h08, '1);
    rc("mask", 8'h10, '1, 32'hc0001afb);
    wr(8'h0c, 32'h00001003);
    rc("mask", 8'h10, '1, 32'hc0000af8);
    // Each raw input alone, so a swapped pair shows up
    for (int i = 0; i < 6; i++) begin
      raw <= 6'(1 << i);
      rc("status raw", 8'h14, '1, 32'h1 << bitpos[i]);
    end
    #1 chk("irq", {31'h0, irq}, 32'h1);
    wr(8'h0c, 32'h80000000);
    #1 chk("irq", {31'h0, irq}, 32'h0);
    raw <= 6'h0;
    wr(8'h20, 32'h1);
    wr(8'h00, 32'h50);
    rc("tx idle", 8'h14, 32'h203, 32'h202);
    fork
      begin
        host.get(c0);
        host.get(c1);
      end
      begin
        wr(8'h1c, 32'ha5);
        wr(8'h1c, 32'h5a);
        rc("tx busy", 8'h14, 32'h203, 32'h0);
      end
    join
    chk("tx char", {24'h0, c0}, 32'ha5);
    chk("tx char", {24'h0, c1}, 32'h5a);
    // Host returns mid-stop; let the last stop bit finish first
    repeat (16) @(posedge ref_clk);
    rc("tx idle", 8'h14, 32'h203, 32'h202);
    wr(8'h00, 32'h80);
    rc("tx off", 8'h14, 32'h203, 32'h0);
    host.send(8'h3c, 1'b0, 1'b1);
    rc("rx flags", 8'h14, 32'he1, 32'h01);
    rc("rx char", 8'h18, 32'hff, 32'h3c);
    rc("rx flags", 8'h14, 32'he1, 32'h0);
    host.send(8'h11, 1'b1, 1'b1);
    rc("rx flags", 8'h14, 32'he1, 32'h81);
    rc("rx char", 8'h18, 32'hff, 32'h11);
    for (int i = 0; i < 4; i++) begin
      host.send(8'h40 + 8'(i), 1'b0, 1'b1);
    end
    rc("rx errors", 8'h14, 32'he0, 32'ha0);
    wr(8'h00, 32'h100);
    rc("rx errors", 8'h14, 32'he0, 32'h0);
    host.send(8'h22, 1'b0, 1'b0);
    rc("rx errors", 8'h14, 32'h40, 32'h40);
    wr(8'h00, 32'h20);
    repeat (200) @(posedge ref_clk);
    rc("rx off", 8'h14, 32'h1, 32'h0);
    rc("baud", 8'h20, '1, 32'h1);
    wr(8'h04, 32'h800);
    rc("mode", 8'h04, '1, 32'h800);
    conclude();
  end
endmodule
`default_nettype wire
